// file: core/rtc_core.sv
// Clock/calendar timekeeping, status and control registers
`timescale 1ns/1ps
module rtc_core (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic xtal_in_pin,
    input wire logic total_loss_in,
    input wire logic backup_mode_in,
    input wire logic alarm_match,
    input wire rtc_pkg::rtc_req_t req,
    output logic [7:0] reg_rdata,
    output logic osc_stop,
    output logic low_power_sel,
    output logic alarm_freq_pin_o,
    output logic alarm_freq_pin_oe,
    output logic clock_running
);
    rtc_pkg::rtc_state_t state_r, state_nxt;
    rtc_pkg::rtc_time_t time_r, time_nxt;
    rtc_pkg::rtc_time_t snap_r, snap_nxt;
    logic [1:0] init_cnt_r, init_cnt_nxt;
    logic [rtc_pkg::DIV_W-1:0] div_r, div_nxt;
    logic [7:0] status_r, status_nxt;
    logic [7:0] irqf_r, irqf_nxt;
    logic [7:0] rdata_nxt;
    logic start_pend_r, start_pend_nxt;
    logic sr_rd_pend_r, sr_rd_pend_nxt;
    logic alm_new_r, alm_new_nxt;
    logic bak_new_r, bak_new_nxt;
    logic drive_r, drive_nxt;
    logic xt_s1, xt_s2, xt_s3;
    logic tl_s1, tl_s2;
    logic bm_s1, bm_s2, bm_s3;
    logic xtal_rise;
    logic bak_rise;
    logic sec_tick;
    logic wr_time;
    logic realign;
    logic fout;
    logic [5:0] last_date;
    logic [4:0] h12;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        if (y[4]) begin
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction

    // Input synchronisers and edge detection
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            xt_s1 <= 1'b0;
            xt_s2 <= 1'b0;
            xt_s3 <= 1'b0;
            tl_s1 <= 1'b0;
            tl_s2 <= 1'b0;
            bm_s1 <= 1'b0;
            bm_s2 <= 1'b0;
            bm_s3 <= 1'b0;
        end else if (clk_en) begin
            xt_s1 <= xtal_in_pin;
            xt_s2 <= xt_s1;
            xt_s3 <= xt_s2;
            tl_s1 <= total_loss_in;
            tl_s2 <= tl_s1;
            bm_s1 <= backup_mode_in;
            bm_s2 <= bm_s1;
            bm_s3 <= bm_s2;
        end
    end

    assign xtal_rise = xt_s2 & ~xt_s3;
    assign bak_rise = bm_s2 & ~bm_s3;
    assign wr_time = req.wr && (req.addr <= rtc_pkg::ADDR_WDAY) && status_r[rtc_pkg::SR_WR_EN];
    assign realign = req.stop && start_pend_r;
    assign sec_tick = (state_r == rtc_pkg::RTC_ST_RUN) && xtal_rise
        && (div_r[14:0] == rtc_pkg::SEC_WRAP) && !realign;
    assign h12 = time_r.hr[4:0];

    always_comb begin
        case (time_r.mth)
            rtc_pkg::MTH_FEB: last_date = is_leap(time_r.year) ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: last_date = 6'h30;
            default: last_date = 6'h31;
        endcase
    end

    // Power-up sequencing and run control
    always_comb begin
        state_nxt = state_r;
        init_cnt_nxt = init_cnt_r;
        start_pend_nxt = start_pend_r;
        if (wr_time) begin
            start_pend_nxt = 1'b1;
        end
        if (req.stop) begin
            start_pend_nxt = 1'b0;
        end
        case (state_r)
            rtc_pkg::RTC_ST_INIT: begin
                init_cnt_nxt = init_cnt_r + 2'h1;
                if (init_cnt_r == rtc_pkg::INIT_CYCLES) begin
                    state_nxt = tl_s2 ? rtc_pkg::RTC_ST_HALT : rtc_pkg::RTC_ST_RUN;
                end
            end
            rtc_pkg::RTC_ST_HALT: begin
                if (realign) begin
                    state_nxt = rtc_pkg::RTC_ST_RUN;
                end
            end
            rtc_pkg::RTC_ST_RUN: state_nxt = rtc_pkg::RTC_ST_RUN;
            default: state_nxt = rtc_pkg::RTC_ST_INIT;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= rtc_pkg::RTC_ST_INIT;
            init_cnt_r <= 2'h0;
            start_pend_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
            start_pend_r <= start_pend_nxt;
        end
    end

    // Timebase divider, one count per rising timebase edge
    always_comb begin
        div_nxt = div_r;
        if (realign) begin
            div_nxt = '0;
        end else if (xtal_rise) begin
            div_nxt = div_r + 20'h00001;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= '0;
        end else if (clk_en) begin
            div_r <= div_nxt;
        end
    end

    // Time and calendar counters
    always_comb begin
        time_nxt = time_r;
        if (sec_tick) begin
            if (time_r.sec != rtc_pkg::BCD_59) begin
                time_nxt.sec = 7'(bcd_inc({1'b0, time_r.sec}));
            end else begin
                time_nxt.sec = 7'h00;
                if (time_r.min != rtc_pkg::BCD_59) begin
                    time_nxt.min = 7'(bcd_inc({1'b0, time_r.min}));
                end else begin
                    time_nxt.min = 7'h00;
                    if (time_r.hour_format_24) begin
                        time_nxt.hr = (time_r.hr == rtc_pkg::HR24_MAX) ? 6'h00 : 6'(bcd_inc({2'b0, time_r.hr}));
                    end else if (h12 == rtc_pkg::HR12_TOP) begin
                        time_nxt.hr = {time_r.hr[5], rtc_pkg::HR12_ONE};
                    end else if (h12 == rtc_pkg::HR12_ELEVEN) begin
                        time_nxt.hr = {~time_r.hr[5], rtc_pkg::HR12_TOP};
                    end else begin
                        time_nxt.hr = {time_r.hr[5], 5'(bcd_inc({3'b0, h12}))};
                    end
                    if ((time_r.hour_format_24 && time_r.hr == rtc_pkg::HR24_MAX)
                        || (!time_r.hour_format_24 && time_r.hr[5] && h12 == rtc_pkg::HR12_ELEVEN)) begin
                        time_nxt.wday = (time_r.wday == rtc_pkg::WDAY_MAX) ? 3'h0 : time_r.wday + 3'h1;
                        if (time_r.date >= last_date) begin
                            time_nxt.date = rtc_pkg::DATE_ONE;
                            if (time_r.mth >= rtc_pkg::MTH_MAX) begin
                                time_nxt.mth = rtc_pkg::MTH_ONE;
                                time_nxt.year = (time_r.year == rtc_pkg::YEAR_MAX) ? 8'h00 : bcd_inc(time_r.year);
                            end else begin
                                time_nxt.mth = 5'(bcd_inc({3'b0, time_r.mth}));
                            end
                        end else begin
                            time_nxt.date = 6'(bcd_inc({2'b0, time_r.date}));
                        end
                    end
                end
            end
        end
        if (wr_time) begin
            case (req.addr)
                rtc_pkg::ADDR_SEC: time_nxt.sec = req.wdata[6:0];
                rtc_pkg::ADDR_MIN: time_nxt.min = req.wdata[6:0];
                rtc_pkg::ADDR_HR: begin
                    time_nxt.hour_format_24 = req.wdata[7];
                    time_nxt.hr = req.wdata[5:0];
                end
                rtc_pkg::ADDR_DATE: time_nxt.date = req.wdata[5:0];
                rtc_pkg::ADDR_MTH: time_nxt.mth = req.wdata[4:0];
                rtc_pkg::ADDR_YEAR: time_nxt.year = req.wdata;
                default: time_nxt.wday = req.wdata[2:0];
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            time_r <= '0;
        end else if (clk_en) begin
            time_r <= time_nxt;
        end
    end

    // Status and control registers
    always_comb begin
        status_nxt = status_r;
        irqf_nxt = irqf_r;
        sr_rd_pend_nxt = sr_rd_pend_r;
        alm_new_nxt = alm_new_r;
        bak_new_nxt = bak_new_r;
        if (req.rd && req.addr == rtc_pkg::ADDR_STATUS) begin
            sr_rd_pend_nxt = 1'b1;
        end
        if (req.wr) begin
            status_nxt[rtc_pkg::SR_LOSS] = 1'b0;
        end
        if (req.wr && req.addr == rtc_pkg::ADDR_STATUS) begin
            status_nxt[rtc_pkg::SR_AUTO_CLR] = req.wdata[rtc_pkg::SR_AUTO_CLR];
            status_nxt[rtc_pkg::SR_OSC_DIS] = req.wdata[rtc_pkg::SR_OSC_DIS];
            status_nxt[rtc_pkg::SR_WR_EN] = req.wdata[rtc_pkg::SR_WR_EN];
            status_nxt[rtc_pkg::SR_ALARM] = status_r[rtc_pkg::SR_ALARM] & req.wdata[rtc_pkg::SR_ALARM];
            status_nxt[rtc_pkg::SR_BACKUP] = status_r[rtc_pkg::SR_BACKUP] & req.wdata[rtc_pkg::SR_BACKUP];
        end
        if (req.wr && req.addr == rtc_pkg::ADDR_IRQF) begin
            irqf_nxt = req.wdata;
        end
        if (req.stop) begin
            if (sr_rd_pend_r && status_r[rtc_pkg::SR_AUTO_CLR]) begin
                if (!alm_new_r) begin
                    status_nxt[rtc_pkg::SR_ALARM] = 1'b0;
                end
                if (!bak_new_r) begin
                    status_nxt[rtc_pkg::SR_BACKUP] = 1'b0;
                end
            end
            sr_rd_pend_nxt = 1'b0;
            alm_new_nxt = 1'b0;
            bak_new_nxt = 1'b0;
        end
        if (alarm_match && (sr_rd_pend_r || sr_rd_pend_nxt) && !req.stop) begin
            alm_new_nxt = 1'b1;
        end
        if (bak_rise && (sr_rd_pend_r || sr_rd_pend_nxt) && !req.stop) begin
            bak_new_nxt = 1'b1;
        end
        if (alarm_match) begin
            status_nxt[rtc_pkg::SR_ALARM] = 1'b1;
        end
        if (bak_rise) begin
            status_nxt[rtc_pkg::SR_BACKUP] = 1'b1;
        end
        if (state_r == rtc_pkg::RTC_ST_INIT && init_cnt_r == rtc_pkg::INIT_CYCLES && tl_s2) begin
            status_nxt[rtc_pkg::SR_LOSS] = 1'b1;
        end
        status_nxt[5] = 1'b0;
        status_nxt[3] = 1'b0;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status_r <= rtc_pkg::STATUS_RST;
            irqf_r <= rtc_pkg::IRQF_RST;
            sr_rd_pend_r <= 1'b0;
            alm_new_r <= 1'b0;
            bak_new_r <= 1'b0;
        end else if (clk_en) begin
            status_r <= status_nxt;
            irqf_r <= irqf_nxt;
            sr_rd_pend_r <= sr_rd_pend_nxt;
            alm_new_r <= alm_new_nxt;
            bak_new_r <= bak_new_nxt;
        end
    end

    // Read snapshot and read data
    always_comb begin
        snap_nxt = snap_r;
        if (req.rd_start) begin
            snap_nxt = time_r;
        end
        rdata_nxt = reg_rdata;
        if (req.rd) begin
            if (req.addr == rtc_pkg::ADDR_SEC) begin
                rdata_nxt = {1'b0, snap_r.sec};
            end else if (req.addr == rtc_pkg::ADDR_MIN) begin
                rdata_nxt = {1'b0, snap_r.min};
            end else if (req.addr == rtc_pkg::ADDR_HR) begin
                rdata_nxt = {snap_r.hour_format_24, 1'b0, snap_r.hr};
            end else if (req.addr == rtc_pkg::ADDR_DATE) begin
                rdata_nxt = {2'b0, snap_r.date};
            end else if (req.addr == rtc_pkg::ADDR_MTH) begin
                rdata_nxt = {3'b0, snap_r.mth};
            end else if (req.addr == rtc_pkg::ADDR_YEAR) begin
                rdata_nxt = snap_r.year;
            end else if (req.addr == rtc_pkg::ADDR_WDAY) begin
                rdata_nxt = {5'b0, snap_r.wday};
            end else if (req.addr == rtc_pkg::ADDR_STATUS) begin
                rdata_nxt = status_r;
            end else if (req.addr == rtc_pkg::ADDR_IRQF) begin
                rdata_nxt = irqf_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            snap_r <= '0;
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            snap_r <= snap_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    rtc_fout_sel u_fout (
        .core_clk(core_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .sel(irqf_r[3:0]),
        .xtal_lvl(xt_s2),
        .div(div_r),
        .fout(fout)
    );

    // Open-drain interrupt/frequency pin, active low
    always_comb begin
        if (irqf_r[rtc_pkg::IRQF_PIN_OFF] && bm_s2) begin
            drive_nxt = 1'b0;
        end else if (irqf_r[3:0] != rtc_pkg::FO_OFF) begin
            drive_nxt = ~fout;
        end else begin
            drive_nxt = irqf_r[rtc_pkg::IRQF_ALM_EN] & status_r[rtc_pkg::SR_ALARM];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            drive_r <= 1'b0;
        end else if (clk_en) begin
            drive_r <= drive_nxt;
        end
    end

    assign alarm_freq_pin_o = 1'b0;
    assign alarm_freq_pin_oe = drive_r;
    assign osc_stop = status_r[rtc_pkg::SR_OSC_DIS];
    assign low_power_sel = irqf_r[rtc_pkg::IRQF_LOWP];
    assign clock_running = (state_r == rtc_pkg::RTC_ST_RUN);
endmodule // rtc_core

// file: core/rtc_pkg.sv
// Package with constants and types for the clock/calendar core
// What this block does
// - Time and calendar held as BCD values
// - Weekday counts zero to six, wraps
// - Hour format bit picks 24h or 12h/PM
// - Every year divisible by four is leap
// - Total-loss flag set only after both supplies lost
// - After total loss, halted until clock write
// - Backup flag set by hardware, host clears only
// - Alarm flag set on match, host clears only
// - Alarm set during status read survives read
// - Time registers writable only with write enable
// - Valid write ending in STOP starts, realigns tick
// - Oscillator disable selects external timebase
// - Auto-clear drops backup, alarm after status read
// - Frequency output overrides alarm on pin
// - Frequency select field decodes fifteen rates plus off
// - Status register bit layout fixed
// - Clock registers snapshotted at read start
package rtc_pkg;
    localparam logic [4:0] ADDR_SEC = 5'h00;
    localparam logic [4:0] ADDR_MIN = 5'h01;
    localparam logic [4:0] ADDR_HR = 5'h02;
    localparam logic [4:0] ADDR_DATE = 5'h03;
    localparam logic [4:0] ADDR_MTH = 5'h04;
    localparam logic [4:0] ADDR_YEAR = 5'h05;
    localparam logic [4:0] ADDR_WDAY = 5'h06;
    localparam logic [4:0] ADDR_STATUS = 5'h07;
    localparam logic [4:0] ADDR_IRQF = 5'h08;
    localparam int SR_AUTO_CLR = 7;
    localparam int SR_OSC_DIS = 6;
    localparam int SR_WR_EN = 4;
    localparam int SR_ALARM = 2;
    localparam int SR_BACKUP = 1;
    localparam int SR_LOSS = 0;
    localparam int IRQF_PULSE = 7;
    localparam int IRQF_ALM_EN = 6;
    localparam int IRQF_LOWP = 5;
    localparam int IRQF_PIN_OFF = 4;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] IRQF_RST = 8'h00;
    localparam int DIV_W = 20;
    localparam logic [14:0] SEC_WRAP = 15'h7fff;
    localparam logic [1:0] INIT_CYCLES = 2'h3;
    localparam logic [6:0] BCD_59 = 7'h59;
    localparam logic [5:0] HR24_MAX = 6'h23;
    localparam logic [4:0] HR12_TOP = 5'h12;
    localparam logic [4:0] HR12_ELEVEN = 5'h11;
    localparam logic [4:0] HR12_ONE = 5'h01;
    localparam logic [5:0] DATE_ONE = 6'h01;
    localparam logic [4:0] MTH_ONE = 5'h01;
    localparam logic [4:0] MTH_MAX = 5'h12;
    localparam logic [4:0] MTH_FEB = 5'h02;
    localparam logic [7:0] YEAR_MAX = 8'h99;
    localparam logic [2:0] WDAY_MAX = 3'h6;
    localparam logic [3:0] FO_OFF = 4'h0;
    localparam logic [3:0] FO_32K = 4'h1;
    localparam logic [3:0] FO_4K = 4'h2;
    localparam logic [3:0] FO_1K = 4'h3;
    localparam logic [3:0] FO_64 = 4'h4;
    localparam logic [4:0] FO_BIT_OFS = 5'h04;
    typedef enum logic [2:0] {
        RTC_ST_INIT = 3'b001,
        RTC_ST_HALT = 3'b010,
        RTC_ST_RUN = 3'b100
    } rtc_state_t;
    typedef struct packed {
        logic [6:0] sec;
        logic [6:0] min;
        logic hour_format_24;
        logic [5:0] hr;
        logic [5:0] date;
        logic [4:0] mth;
        logic [7:0] year;
        logic [2:0] wday;
    } rtc_time_t;
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic rd_start;
        logic stop;
    } rtc_req_t;
endpackage

// file: core/rtc_fout_sel.sv
// Frequency output selector from the timebase divider
`timescale 1ns/1ps
module rtc_fout_sel (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [3:0] sel,
    input wire logic xtal_lvl,
    input wire logic [rtc_pkg::DIV_W-1:0] div,
    output logic fout
);
    logic fout_nxt;
    logic [4:0] bit_idx;

    always_comb begin
        bit_idx = 5'(sel) + rtc_pkg::FO_BIT_OFS;
        case (sel)
            rtc_pkg::FO_OFF: fout_nxt = 1'b1;
            rtc_pkg::FO_32K: fout_nxt = xtal_lvl;
            rtc_pkg::FO_4K: fout_nxt = div[2];
            rtc_pkg::FO_1K: fout_nxt = div[4];
            rtc_pkg::FO_64: fout_nxt = div[8];
            default: fout_nxt = div[bit_idx];
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fout <= 1'b1;
        end else if (clk_en) begin
            fout <= fout_nxt;
        end
    end
endmodule // rtc_fout_sel

// file: tb/rtc_core_props.sv
// Checker for the clock/calendar core ports
`timescale 1ns/1ps
module rtc_core_props (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic alarm_match,
    input wire rtc_pkg::rtc_req_t req,
    input wire logic [7:0] reg_rdata,
    input wire logic osc_stop,
    input wire logic alarm_freq_pin_o,
    input wire logic alarm_freq_pin_oe,
    input wire logic clock_running
);
    logic [7:0] irqf_r, irqf_nxt;
    logic [3:0] age_r, age_nxt;
    logic [1:0] quiet_r, quiet_nxt;
    logic wrote_r, wrote_nxt;
    logic rd7;
    assign rd7 = clk_en && req.rd && req.addr == rtc_pkg::ADDR_STATUS;
    // Shadow of the pin control register, age since reset, quiet-pin count
    always_comb begin
        irqf_nxt = irqf_r;
        if (clk_en && req.wr && req.addr == rtc_pkg::ADDR_IRQF) begin
            irqf_nxt = req.wdata;
        end
        age_nxt = (age_r == 4'hf) ? age_r : age_r + 4'h1;
        wrote_nxt = wrote_r | (clk_en && req.wr && age_r == 4'hf);
        quiet_nxt = (irqf_r[6] || irqf_r[3:0] != 4'h0) ? 2'h0 : ((quiet_r == 2'h3) ? quiet_r : quiet_r + 2'h1);
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irqf_r <= 8'h00;
            age_r <= 4'h0;
            quiet_r <= 2'h0;
            wrote_r <= 1'b0;
        end else begin
            irqf_r <= irqf_nxt;
            age_r <= age_nxt;
            quiet_r <= quiet_nxt;
            wrote_r <= wrote_nxt;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_pin_drive_low: assert property (alarm_freq_pin_o == 1'b0)
        else $error("pin output not low");
    a_rsvd_bits_zero: assert property (rd7 |=> reg_rdata[5] == 1'b0 && reg_rdata[3] == 1'b0)
        else $error("reserved status bits read nonzero");
    a_unmapped_zero: assert property (clk_en && req.rd && req.addr > rtc_pkg::ADDR_IRQF |=> reg_rdata == 8'h00)
        else $error("unmapped read nonzero");
    a_osc_bit_follow: assert property (clk_en && req.wr && req.addr == rtc_pkg::ADDR_STATUS
        |-> ##2 osc_stop == $past(req.wdata[6], 2)) else $error("oscillator stop wrong");
    a_loss_flag_ro: assert property (rd7 && wrote_r && age_r == 4'hf |=> reg_rdata[0] == 1'b0)
        else $error("loss flag still set after write");
    a_run_after_stop: assert property ($rose(clock_running) && age_r == 4'hf
        |-> $past(req.stop) || $past(req.stop, 2)) else $error("clock started without stop");
    a_run_sticky: assert property (clock_running |=> clock_running)
        else $error("clock stopped while running");
    a_rdata_holds: assert property (!(clk_en && req.rd) |=> $stable(reg_rdata))
        else $error("read data changed without read");
    a_quiet_pin: assert property (quiet_r == 2'h3 |-> !alarm_freq_pin_oe)
        else $error("pin driven while output off");
    a_alarm_drive: assert property (alarm_match && clk_en && irqf_r[6] && irqf_r[4:0] == 5'h00
        |-> ##[1:3] alarm_freq_pin_oe) else $error("alarm did not drive pin");
    c_clock_start: cover property ($rose(clock_running));
    c_alarm_pin: cover property ($rose(alarm_freq_pin_oe));
    c_status_read: cover property (rd7);
endmodule // rtc_core_props
bind rtc_core rtc_core_props rtc_core_props_i (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .alarm_match(alarm_match), .req(req), .reg_rdata(reg_rdata), .osc_stop(osc_stop),
    .alarm_freq_pin_o(alarm_freq_pin_o), .alarm_freq_pin_oe(alarm_freq_pin_oe), .clock_running(clock_running));

// file: tb/rtc_host_model.sv
// Host side model that issues register requests
`timescale 1ns/1ps
module rtc_host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output rtc_pkg::rtc_req_t req
);
    initial begin
        req = '0;
    end
    // Kind bits are wr, rd, rd_start, stop; idle address and data lines show the inverse, kind bits zero
    task automatic pulse(input logic [4:0] a, input logic [7:0] d, input logic [3:0] k);
        @(negedge core_clk);
        req <= {a, d, k};
        @(negedge core_clk);
        req <= {~a, ~d, 4'h0};
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        pulse(a, d, 4'h8);
        pulse(a, d, 4'h1);
        repeat (2) @(negedge core_clk);
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
        pulse(a, 8'h00, 4'h2);
        pulse(a, 8'h00, 4'h4);
        @(negedge core_clk);
        d = reg_rdata;
        pulse(a, 8'h00, 4'h1);
        repeat (2) @(negedge core_clk);
    endtask
endmodule // rtc_host_model

// file: tb/rtc_core_test.sv
// Self-checking bench for the clock/calendar core
`timescale 1ns/1ps
module rtc_core_test;
    logic core_clk, nrst, clk_en, xtal_in_pin, total_loss_in, backup_mode_in, alarm_match;
    logic [7:0] reg_rdata, d, v;
    logic osc_stop, low_power_sel, pin_o, pin_oe, clock_running;
    rtc_pkg::rtc_req_t req;
    logic [31:0] rnd;
    int n_mismatch, n_compared, a, n;
    int half [5] = '{0, 4, 32, 128, 2048};
    logic [4:0] c_ad [7] = '{5'h02, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00};
    logic [7:0] c_val [7] = '{8'h32, 8'ha3, 8'h31, 8'h12, 8'h99, 8'h06, 8'h59};
    wire pin_lvl = pin_oe ? pin_o : 1'b1;
    rtc_core rtc_core_i (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .xtal_in_pin(xtal_in_pin),
        .total_loss_in(total_loss_in), .backup_mode_in(backup_mode_in), .alarm_match(alarm_match), .req(req),
        .reg_rdata(reg_rdata), .osc_stop(osc_stop), .low_power_sel(low_power_sel), .alarm_freq_pin_o(pin_o),
        .alarm_freq_pin_oe(pin_oe), .clock_running(clock_running));
    rtc_host_model rtc_host_model_i (.core_clk(core_clk), .reg_rdata(reg_rdata), .req(req));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] bcd(input int x);
        return 8'((x / 10) * 16 + x % 10);
    endfunction
    function automatic logic [7:0] pick(input int ad, input logic [31:0] r);
        case (ad)
            0, 1: return bcd(int'(r % 60));
            2: return 8'h80 | bcd(int'(r % 24));
            3: return bcd(int'(r % 31) + 1);
            4: return bcd(int'(r % 12) + 1);
            5: return bcd(int'(r % 100));
            6: return bcd(int'(r % 7));
            default: return r[7:0];
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] ad, input logic [7:0] dv);
        rtc_host_model_i.wr_reg(ad, dv);
    endtask
    task automatic rd_chk(input logic [4:0] ad, input logic [7:0] exp);
        rtc_host_model_i.rd_reg(ad, d);
        check(d, exp);
    endtask
    task automatic alarm_pulse();
        @(negedge core_clk);
        alarm_match = 1'b1;
        @(negedge core_clk);
        alarm_match = 1'b0;
    endtask
    task automatic freq_win(input int cyc);
        logic last;
        n = 0;
        repeat (8) @(negedge core_clk);
        last = pin_lvl;
        repeat (cyc) begin
            @(negedge core_clk);
            if (pin_lvl !== last) n++;
            last = pin_lvl;
        end
    endtask
    task automatic results();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        xtal_in_pin = 1'b0;
        #37;
        forever #100 xtal_in_pin = ~xtal_in_pin;
    end
    initial begin
        #2000000;
        n_mismatch++;
        results();
    end
    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        total_loss_in = 1'b1;
        backup_mode_in = 1'b0;
        alarm_match = 1'b0;
        rnd = 32'hd973;
        repeat (5) @(negedge core_clk);
        check({4'h0, pin_oe, osc_stop, low_power_sel, clock_running}, 8'h00);
        check(reg_rdata, 8'h00);
        nrst = 1'b1;
        repeat (8) @(negedge core_clk);
        check({7'h0, clock_running}, 8'h00);
        rd_chk(rtc_pkg::ADDR_STATUS, 8'h01);
        wr(rtc_pkg::ADDR_SEC, 8'h30);
        rd_chk(rtc_pkg::ADDR_SEC, 8'h00);
        wr(rtc_pkg::ADDR_STATUS, 8'h10);
        rd_chk(rtc_pkg::ADDR_STATUS, 8'h10);
        check({7'h0, clock_running}, 8'h00);
        wr(rtc_pkg::ADDR_SEC, 8'h30);
        check({7'h0, clock_running}, 8'h01);
        rd_chk(rtc_pkg::ADDR_SEC, 8'h30);
        // Second reset with one supply kept: no loss flag, clock runs
        @(negedge core_clk);
        nrst = 1'b0;
        total_loss_in = 1'b0;
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        repeat (8) @(negedge core_clk);
        check({7'h0, clock_running}, 8'h01);
        rd_chk(rtc_pkg::ADDR_STATUS, 8'h00);
        rd_chk(rtc_pkg::ADDR_IRQF, 8'h00);
        rd_chk(rtc_pkg::ADDR_WDAY, 8'h00);
        rd_chk(rtc_pkg::ADDR_HR, 8'h00);
        wr(rtc_pkg::ADDR_STATUS, 8'h10);
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            a = int'(rnd[2:0]);
            if (a == 7) a = 8;
            v = pick(a, rnd >> 8);
            wr(5'(a), v);
            rd_chk(5'(a), v);
        end
        foreach (c_ad[i]) begin
            wr(c_ad[i], c_val[i]);
            rd_chk(c_ad[i], c_val[i]);
        end
        wr(rtc_pkg::ADDR_STATUS, 8'h00);
        wr(rtc_pkg::ADDR_SEC, 8'h11);
        rd_chk(rtc_pkg::ADDR_SEC, 8'h59);
        wr(rtc_pkg::ADDR_STATUS, 8'hff);
        rd_chk(rtc_pkg::ADDR_STATUS, 8'hd0);
        check({7'h0, osc_stop}, 8'h01);
        backup_mode_in = 1'b1;
        repeat (6) @(negedge core_clk);
        rd_chk(rtc_pkg::ADDR_STATUS, 8'hd2);
        rd_chk(rtc_pkg::ADDR_STATUS, 8'hd0);
        backup_mode_in = 1'b0;
        // Alarm arrives between snapshot and STOP of a status read
        rtc_host_model_i.pulse(rtc_pkg::ADDR_STATUS, 8'h00, 4'h2);
        rtc_host_model_i.pulse(rtc_pkg::ADDR_STATUS, 8'h00, 4'h4);
        alarm_pulse();
        rtc_host_model_i.pulse(rtc_pkg::ADDR_STATUS, 8'h00, 4'h1);
        rd_chk(rtc_pkg::ADDR_STATUS, 8'hd4);
        rd_chk(rtc_pkg::ADDR_STATUS, 8'hd0);
        wr(rtc_pkg::ADDR_STATUS, 8'h10);
        alarm_pulse();
        rd_chk(rtc_pkg::ADDR_STATUS, 8'h14);
        rd_chk(rtc_pkg::ADDR_STATUS, 8'h14);
        wr(rtc_pkg::ADDR_STATUS, 8'h16);
        rd_chk(rtc_pkg::ADDR_STATUS, 8'h14);
        wr(rtc_pkg::ADDR_IRQF, 8'h40);
        alarm_pulse();
        repeat (4) @(negedge core_clk);
        check({7'h0, pin_oe}, 8'h01);
        for (int c = 1; c < 5; c++) begin
            wr(rtc_pkg::ADDR_IRQF, 8'h40 | 8'(c));
            freq_win(half[c] * 4);
            check({7'h0, n >= 3 && n <= 5}, 8'h01);
        end
        wr(rtc_pkg::ADDR_STATUS, 8'h10);
        wr(rtc_pkg::ADDR_IRQF, 8'h00);
        wr(5'h09, 8'h5a);
        rd_chk(5'h09, 8'h00);
        results();
    end
endmodule // rtc_core_test
